// ==== design/gif_cfg.svh ====
// Constants for the global interrupt flag block: offsets, bit positions and reset values.
`ifndef GIF_CFG_SVH
`define GIF_CFG_SVH

// ==========================================================================
// Register offsets and reset values
// ==========================================================================
`define GIF_LOW_OFFSET 8'h00
`define GIF_HIGH_OFFSET 8'h04
`define GIF_FLAGS_RESET 8'h00
`define GIF_UNMAPPED_READ 8'h00
`define GIF_RESERVED_READ 1'b0

// ==========================================================================
// Bit positions in the low flag register
// ==========================================================================
`define GIF_LO_LDO_A_DROP 7
`define GIF_LO_LDO_B_DROP 6
`define GIF_LO_THERM_TWO 5
`define GIF_LO_THERM_ONE 4
`define GIF_LO_EN_RISE 3
`define GIF_LO_EN_FALL 2
`define GIF_LO_PIN_A_RISE 1
`define GIF_LO_PIN_A_FALL 0

// ==========================================================================
// Bit positions in the high flag register
// ==========================================================================
`define GIF_HI_RESERVED 7
`define GIF_HI_LDO_B_FAULT 6
`define GIF_HI_LDO_A_FAULT 5
`define GIF_HI_TIMEOUT 4
`define GIF_HI_PIN_C_RISE 3
`define GIF_HI_PIN_C_FALL 2
`define GIF_HI_PIN_B_RISE 1
`define GIF_HI_PIN_B_FALL 0

// ==========================================================================
// Positions in the synchronised event vector
// ==========================================================================
`define GIF_EV_LDO_A_DROP 0
`define GIF_EV_LDO_B_DROP 1
`define GIF_EV_THERM_TWO 2
`define GIF_EV_THERM_ONE 3
`define GIF_EV_EN_PIN 4
`define GIF_EV_PIN_A 5
`define GIF_EV_PIN_B 6
`define GIF_EV_PIN_C 7
`define GIF_EV_LDO_A_FAULT 8
`define GIF_EV_LDO_B_FAULT 9
`define GIF_EV_TIMEOUT 10
`define GIF_EV_WIDTH 11
`define GIF_EV_RESET 11'h000
`define GIF_ARM_RESET 2'h0

`endif

// ==== design/gif_pkg.sv ====
// Types shared by the global interrupt flag block.
`include "gif_cfg.svh"
package gif_pkg;
	typedef logic [7:0] gif_byte_t;
	typedef logic [`GIF_EV_WIDTH-1:0] gif_events_t;
	typedef logic [2:0] gif_pins_t;
	typedef logic [15:0] gif_mask_t;
endpackage

// ==== design/gif_global_flags.sv ====
// Global interrupt flag registers with read-to-clear and interrupt drive.
//
// Notes on behaviour
// - Flags stay set until register read clears.
// - Low bits 7/6 catch dropout onset.
// - Low bits 5/4 catch thermal threshold crossings.
// - Low bit 3 catches enable pin rise.
// - Low bit 2 catches enable pin fall.
// - Input pin rising edges set rise flags.
// - Input pin falling edges set fall flags.
// - Input pin edges count only when configured input.
// - High bits 6/5 catch regulator faults.
// - High bit 4 catches buck-boost timeout.
// - High bit 7 reserved, reads zero here.
// - Interrupt drive from unmasked flags, readable status.
`timescale 1ns/100ps
`include "gif_cfg.svh"

module gif_global_flags #(
	parameter int ADDR_W = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic ldo_a_dropout_i,
	input wire logic ldo_b_dropout_i,
	input wire logic thermal_alarm_one_i,
	input wire logic thermal_alarm_two_i,
	input wire logic active_low_enable_pin_n_i,
	input wire gif_pkg::gif_pins_t input_pin_i,
	input wire gif_pkg::gif_pins_t input_pin_is_input_i,
	input wire logic ldo_a_fault_i,
	input wire logic ldo_b_fault_i,
	input wire logic buck_boost_timeout_i,
	input wire gif_pkg::gif_mask_t flag_mask_i,
	input wire logic reg_rd_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	output gif_pkg::gif_byte_t reg_rd_data_o,
	output logic reg_rd_valid_o,
	output logic irq_status_o,
	output logic interrupt_request_pin_o,
	output logic interrupt_request_pin_oe_n_o
);
	import gif_pkg::*;

	localparam logic [ADDR_W-1:0] LOW_ADDR = ADDR_W'(`GIF_LOW_OFFSET);
	localparam logic [ADDR_W-1:0] HIGH_ADDR = ADDR_W'(`GIF_HIGH_OFFSET);

	if (ADDR_W < 3) begin : g_bad_addr
		$error("ADDR_W too narrow to hold the register offsets");
	end

	// ======================================================================
	// Input synchronisers
	// ======================================================================
	gif_events_t raw_ev;
	gif_events_t sync1_r;
	gif_events_t sync2_r;

	assign raw_ev = {buck_boost_timeout_i, ldo_b_fault_i, ldo_a_fault_i, input_pin_i,
		active_low_enable_pin_n_i, thermal_alarm_one_i, thermal_alarm_two_i,
		ldo_b_dropout_i, ldo_a_dropout_i};

	for (genvar i = 0; i < `GIF_EV_WIDTH; i++) begin : g_sync
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				sync1_r[i] <= 1'b0;
				sync2_r[i] <= 1'b0;
			end else begin
				sync1_r[i] <= raw_ev[i];
				sync2_r[i] <= sync1_r[i];
			end
		end
	end

	// ======================================================================
	// Edge detection
	// ======================================================================
	// The arm counter holds off edge detection until the synchronisers carry
	// real pin levels, so reset release does not fake an edge.
	gif_events_t prev_r;
	gif_events_t prev_nxt;
	logic [1:0] arm_r;
	logic [1:0] arm_nxt;
	logic armed;
	gif_events_t rise;
	gif_events_t fall;

	always_comb begin
		prev_nxt = sync2_r;
		arm_nxt = armed ? arm_r : arm_r + 2'h1;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			prev_r <= `GIF_EV_RESET;
			arm_r <= `GIF_ARM_RESET;
		end else begin
			prev_r <= prev_nxt;
			arm_r <= arm_nxt;
		end
	end

	assign armed = (arm_r == 2'h3);
	assign rise = sync2_r & ~prev_r & {`GIF_EV_WIDTH{armed}};
	assign fall = ~sync2_r & prev_r & {`GIF_EV_WIDTH{armed}};

	// ======================================================================
	// Flag set terms
	// ======================================================================
	gif_byte_t set_low;
	gif_byte_t set_high;

	always_comb begin
		set_low = 8'h00;
		set_high = 8'h00;
		set_low[`GIF_LO_LDO_A_DROP] = rise[`GIF_EV_LDO_A_DROP];
		set_low[`GIF_LO_LDO_B_DROP] = rise[`GIF_EV_LDO_B_DROP];
		set_low[`GIF_LO_THERM_TWO] = rise[`GIF_EV_THERM_TWO];
		set_low[`GIF_LO_THERM_ONE] = rise[`GIF_EV_THERM_ONE];
		set_low[`GIF_LO_EN_RISE] = rise[`GIF_EV_EN_PIN];
		set_low[`GIF_LO_EN_FALL] = fall[`GIF_EV_EN_PIN];
		set_low[`GIF_LO_PIN_A_RISE] = rise[`GIF_EV_PIN_A] & input_pin_is_input_i[0];
		set_low[`GIF_LO_PIN_A_FALL] = fall[`GIF_EV_PIN_A] & input_pin_is_input_i[0];
		set_high[`GIF_HI_LDO_B_FAULT] = rise[`GIF_EV_LDO_B_FAULT];
		set_high[`GIF_HI_LDO_A_FAULT] = rise[`GIF_EV_LDO_A_FAULT];
		set_high[`GIF_HI_TIMEOUT] = rise[`GIF_EV_TIMEOUT];
		set_high[`GIF_HI_PIN_C_RISE] = rise[`GIF_EV_PIN_C] & input_pin_is_input_i[2];
		set_high[`GIF_HI_PIN_C_FALL] = fall[`GIF_EV_PIN_C] & input_pin_is_input_i[2];
		set_high[`GIF_HI_PIN_B_RISE] = rise[`GIF_EV_PIN_B] & input_pin_is_input_i[1];
		set_high[`GIF_HI_PIN_B_FALL] = fall[`GIF_EV_PIN_B] & input_pin_is_input_i[1];
	end

	// ======================================================================
	// Flag registers and read port
	// ======================================================================
	// A read returns the flags as they stood before the clear; an event in the
	// read cycle is kept and shows on the following read.
	gif_byte_t flags_low_r;
	gif_byte_t flags_low_nxt;
	gif_byte_t flags_high_r;
	gif_byte_t flags_high_nxt;
	gif_byte_t rd_data_r;
	gif_byte_t rd_data_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic rd_low;
	logic rd_high;

	assign rd_low = reg_rd_i && (reg_addr_i == LOW_ADDR);
	assign rd_high = reg_rd_i && (reg_addr_i == HIGH_ADDR);

	always_comb begin
		flags_low_nxt = (flags_low_r & ~{8{rd_low}}) | set_low;
		flags_high_nxt = (flags_high_r & ~{8{rd_high}}) | set_high;
		rd_valid_nxt = reg_rd_i;
		rd_data_nxt = rd_data_r;
		if (rd_low) begin
			rd_data_nxt = flags_low_r;
		end else if (rd_high) begin
			rd_data_nxt = flags_high_r;
			rd_data_nxt[`GIF_HI_RESERVED] = `GIF_RESERVED_READ;
		end else if (reg_rd_i) begin
			rd_data_nxt = `GIF_UNMAPPED_READ;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags_low_r <= `GIF_FLAGS_RESET;
			flags_high_r <= `GIF_FLAGS_RESET;
			rd_data_r <= `GIF_FLAGS_RESET;
			rd_valid_r <= 1'b0;
		end else begin
			flags_low_r <= flags_low_nxt;
			flags_high_r <= flags_high_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	assign reg_rd_data_o = rd_data_r;
	assign reg_rd_valid_o = rd_valid_r;

	// ======================================================================
	// Interrupt drive
	// ======================================================================
	// The pin is open drain: it is pulled low while the drive is active.
	logic pending;
	logic irq_r;
	logic irq_nxt;
	logic oe_n_r;
	logic oe_n_nxt;
	logic pin_r;
	logic pin_nxt;

	assign pending = |({flags_high_r, flags_low_r} & ~flag_mask_i);

	always_comb begin
		irq_nxt = pending;
		oe_n_nxt = ~pending;
		pin_nxt = 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			irq_r <= 1'b0;
			oe_n_r <= 1'b1;
			pin_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
			oe_n_r <= oe_n_nxt;
			pin_r <= pin_nxt;
		end
	end

	assign irq_status_o = irq_r;
	assign interrupt_request_pin_oe_n_o = oe_n_r;
	assign interrupt_request_pin_o = pin_r;

	// ======================================================================
	// Assertions
	// ======================================================================
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	read_clears_low_a: assert property (
		(reg_rd_i && reg_addr_i == LOW_ADDR && set_low == 8'h00) |=> flags_low_r == 8'h00)
		else $error("low flags not cleared by read");

	flag_holds_a: assert property (
		(flags_high_r[`GIF_HI_TIMEOUT] && !rd_high) |=> flags_high_r[`GIF_HI_TIMEOUT])
		else $error("timeout flag dropped without a read");

	read_returns_old_a: assert property (
		rd_low |=> (reg_rd_valid_o && reg_rd_data_o == $past(flags_low_r)))
		else $error("read data differs from flags before clear");

	dropout_sets_a: assert property (
		($rose(ldo_a_dropout_i) && armed) |-> ##3 flags_low_r[`GIF_LO_LDO_A_DROP])
		else $error("dropout onset did not set its flag");

	thermal_sets_a: assert property (
		rise[`GIF_EV_THERM_TWO] |=> flags_low_r[`GIF_LO_THERM_TWO])
		else $error("thermal alarm crossing did not set its flag");

	enable_rise_a: assert property (
		($rose(sync2_r[`GIF_EV_EN_PIN]) && armed) |=> flags_low_r[`GIF_LO_EN_RISE])
		else $error("enable pin rise not flagged");

	enable_fall_a: assert property (
		($fell(sync2_r[`GIF_EV_EN_PIN]) && armed) |=> flags_low_r[`GIF_LO_EN_FALL])
		else $error("enable pin fall not flagged");

	pin_rise_a: assert property (
		($rose(sync2_r[`GIF_EV_PIN_B]) && armed && input_pin_is_input_i[1])
		|=> flags_high_r[`GIF_HI_PIN_B_RISE])
		else $error("input pin rise not flagged");

	pin_fall_a: assert property (
		($fell(sync2_r[`GIF_EV_PIN_C]) && armed && input_pin_is_input_i[2])
		|=> flags_high_r[`GIF_HI_PIN_C_FALL])
		else $error("input pin fall not flagged");

	output_pin_quiet_a: assert property (
		(!input_pin_is_input_i[0] && !flags_low_r[`GIF_LO_PIN_A_RISE])
		|=> !flags_low_r[`GIF_LO_PIN_A_RISE])
		else $error("edge flagged on a pin set as output");

	fault_sets_a: assert property (
		rise[`GIF_EV_LDO_B_FAULT] |=> flags_high_r[`GIF_HI_LDO_B_FAULT])
		else $error("regulator fault not flagged");

	timeout_sets_a: assert property (
		rise[`GIF_EV_TIMEOUT] |=> flags_high_r[`GIF_HI_TIMEOUT])
		else $error("buck-boost timeout not flagged");

	reserved_zero_a: assert property (
		rd_high |=> !reg_rd_data_o[`GIF_HI_RESERVED])
		else $error("reserved bit read back as one");

	irq_follows_a: assert property (
		pending |=> (irq_status_o && !interrupt_request_pin_oe_n_o))
		else $error("interrupt drive missing for unmasked flag");

	irq_quiet_a: assert property (
		!pending |=> (!irq_status_o && interrupt_request_pin_oe_n_o))
		else $error("interrupt drive without unmasked flag");

	no_event_loss_a: assert property (
		(rd_low && set_low != 8'h00)
		|=> ((flags_low_r & $past(set_low)) == $past(set_low)))
		else $error("event lost during a read");

	read_clears_high_a: assert property (
		(rd_high && set_high == 8'h00) |=> flags_high_r == 8'h00)
		else $error("high flags not cleared by read");

	unmapped_keeps_a: assert property (
		(reg_rd_i && !rd_low && !rd_high)
		|=> ((flags_low_r & $past(flags_low_r)) == $past(flags_low_r)))
		else $error("read of an unmapped offset cleared flags");

	valid_pulse_a: assert property (
		reg_rd_valid_o == $past(reg_rd_i))
		else $error("read valid is not a one-cycle answer");

endmodule // gif_global_flags

// ==== verification/gif_host_model.sv ====
// Host processor model that reads the global flag registers.
`timescale 1ns/100ps

module gif_host_model (
	input wire logic clk_i,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	input wire gif_pkg::gif_byte_t reg_rd_data_i,
	input wire logic reg_rd_valid_i
);
	import gif_pkg::*;

	initial begin
		reg_rd_o = 1'b0;
		reg_addr_o = 8'hFF;
	end

	// ======================================================================
	// One register read
	// ======================================================================
	// The strobe is held to the taking edge and the answer taken at the next edge.
	task automatic read_reg(input logic [7:0] addr, output gif_byte_t data, output logic valid);
		@(posedge clk_i);
		reg_rd_o <= 1'b1;
		reg_addr_o <= addr;
		@(posedge clk_i);
		reg_rd_o <= 1'b0;
		// An idle address shows the inverse so stale values never look valid.
		reg_addr_o <= ~addr;
		@(posedge clk_i);
		data = reg_rd_data_i;
		valid = reg_rd_valid_i;
		// The host discards the reserved top bit of the high register.
		if (addr == 8'h04) begin
			data[7] = 1'b0;
		end
	endtask
endmodule // gif_host_model

// ==== verification/global_interrupt_flags_test.sv ====
// Self-checking testbench for the global interrupt flag block.
`timescale 1ns/100ps
`include "gif_cfg.svh"

module global_interrupt_flags_test;
	import gif_pkg::*;

	// ======================================================================
	// Clock, stimulus and design
	// ======================================================================
	logic clk_i, arst_n_i, rd, irq, pin, oe_n, v;
	logic [7:0] addr, ua;
	logic [10:0] ev_lvl, nv;
	gif_byte_t rd_data, d1, d2;
	logic rd_valid;
	gif_pins_t dir, nd;
	gif_mask_t mask, nm, ex;
	int mismatches, n_checks, seed;

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	gif_global_flags u_dut (
		.clk_i(clk_i), .arst_n_i(arst_n_i),
		.ldo_a_dropout_i(ev_lvl[`GIF_EV_LDO_A_DROP]),
		.ldo_b_dropout_i(ev_lvl[`GIF_EV_LDO_B_DROP]),
		.thermal_alarm_one_i(ev_lvl[`GIF_EV_THERM_ONE]),
		.thermal_alarm_two_i(ev_lvl[`GIF_EV_THERM_TWO]),
		.active_low_enable_pin_n_i(ev_lvl[`GIF_EV_EN_PIN]),
		.input_pin_i(ev_lvl[7:5]), .input_pin_is_input_i(dir),
		.ldo_a_fault_i(ev_lvl[`GIF_EV_LDO_A_FAULT]),
		.ldo_b_fault_i(ev_lvl[`GIF_EV_LDO_B_FAULT]),
		.buck_boost_timeout_i(ev_lvl[`GIF_EV_TIMEOUT]),
		.flag_mask_i(mask), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_rd_data_o(rd_data), .reg_rd_valid_o(rd_valid), .irq_status_o(irq),
		.interrupt_request_pin_o(pin), .interrupt_request_pin_oe_n_o(oe_n)
	);

	gif_host_model u_host (
		.clk_i(clk_i), .reg_rd_o(rd), .reg_addr_o(addr),
		.reg_rd_data_i(rd_data), .reg_rd_valid_i(rd_valid)
	);

	// ======================================================================
	// Expectations and comparisons
	// ======================================================================
	// Flags that one change of input levels should leave, high byte above low.
	function automatic gif_mask_t edge_flags(logic [10:0] o, logic [10:0] n, gif_pins_t d);
		logic [10:0] r, f;
		gif_mask_t e;
		r = n & ~o;
		f = o & ~n;
		e = 16'h0000;
		e[7] = r[0];
		e[6] = r[1];
		e[5] = r[2];
		e[4] = r[3];
		e[3] = r[4];
		e[2] = f[4];
		e[1] = r[5] & d[0];
		e[0] = f[5] & d[0];
		e[9] = r[6] & d[1];
		e[8] = f[6] & d[1];
		e[11] = r[7] & d[2];
		e[10] = f[7] & d[2];
		e[13] = r[8];
		e[14] = r[9];
		e[12] = r[10];
		return e;
	endfunction

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic chk_byte(input string what, input gif_byte_t exp, input gif_byte_t got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input gif_byte_t exp, input string what);
		gif_byte_t d;
		logic ok;
		u_host.read_reg(a, d, ok);
		chk_bit("read valid", 1'b1, ok);
		chk_byte(what, exp, d);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ======================================================================
	// Main sequence and watchdog
	// ======================================================================
	initial begin
		#20000;
		mismatches++;
		tally_and_finish;
	end

	initial begin
		seed = 76814;
		mismatches = 0;
		n_checks = 0;
		arst_n_i = 1'b0;
		ev_lvl = 11'h000;
		dir = 3'h0;
		mask = 16'h0000;
		repeat (2) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		rd_chk(8'h00, 8'h00, "low reset");
		rd_chk(8'h04, 8'h00, "high reset");
		// A dropout onset at each of 7 distances from a read is reported exactly once.
		for (int k = 0; k < 7; k++) begin
			@(posedge clk_i);
			ev_lvl[`GIF_EV_LDO_A_DROP] <= 1'b1;
			repeat (k) @(posedge clk_i);
			u_host.read_reg(8'h00, d1, v);
			u_host.read_reg(8'h00, d2, v);
			chk_bit("dropout once", 1'b1, d1[7] ^ d2[7]);
			@(posedge clk_i);
			ev_lvl[`GIF_EV_LDO_A_DROP] <= 1'b0;
			repeat (6) @(posedge clk_i);
		end
		for (int i = 0; i < 100; i++) begin
			nv = ev_lvl ^ 11'($random(seed));
			nd = 3'($random(seed));
			nm = gif_mask_t'($random(seed));
			if (i < 4) begin
				nv = (i % 2 == 0) ? 11'h7FF : 11'h000;
				nd = (i < 2) ? 3'h7 : 3'h0;
				nm = (i == 0) ? 16'h0000 : 16'hFFFF;
			end
			ua = 8'($random(seed)) | 8'h01;
			ex = edge_flags(ev_lvl, nv, nd);
			@(posedge clk_i);
			ev_lvl <= nv;
			dir <= nd;
			mask <= nm;
			repeat (6) @(posedge clk_i);
			chk_bit("irq status", |(ex & ~nm), irq);
			chk_bit("irq enable", ~|(ex & ~nm), oe_n);
			chk_bit("irq pin", 1'b0, pin);
			rd_chk(ua, 8'h00, "unmapped");
			rd_chk(8'h00, ex[7:0], "low flags");
			rd_chk(8'h04, ex[15:8], "high flags");
			rd_chk(8'h00, 8'h00, "low cleared");
			rd_chk(8'h04, 8'h00, "high cleared");
			@(posedge clk_i);
			chk_bit("irq idle", 1'b0, irq);
		end
		// A reset in mid-run drops every pending flag and the interrupt drive.
		@(posedge clk_i);
		ev_lvl <= ~ev_lvl;
		dir <= 3'h7;
		mask <= 16'h0000;
		repeat (6) @(posedge clk_i);
		chk_bit("irq before reset", 1'b1, irq);
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk_bit("irq in reset", 1'b0, irq);
		chk_bit("enable in reset", 1'b1, oe_n);
		chk_bit("valid in reset", 1'b0, rd_valid);
		arst_n_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk_bit("irq after reset", 1'b0, irq);
		rd_chk(8'h00, 8'h00, "low after reset");
		rd_chk(8'h04, 8'h00, "high after reset");
		tally_and_finish;
	end
endmodule // global_interrupt_flags_test
